//--- liu_pkg.sv
// Shared constants and carrier types for the line interface control block.
// Assumes one 25 MHz clock domain and an AXI4-Lite register bus.
package liu_pkg;

    // ****************************************
    // Register map (indices, byte address is four times)
    // ****************************************
    localparam logic [7:0] COM5_IDX = 8'h15;
    localparam logic [7:0] LINE_IDX = 8'h17;
    localparam logic [7:0] PINA_IDX = 8'h1A;
    localparam logic [7:0] PINB_IDX = 8'h1B;
    localparam logic [7:0] STAT_IDX = 8'h20;
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [7:0] OUTC_RST = 8'h00;
    localparam logic [7:0] COM5_RST = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BUILD_OUT_LSB = 5;
    localparam int EQ_GAIN_BIT = 4;
    localparam int JA_SIDE_BIT = 3;
    localparam int JA_DEPTH_BIT = 2;
    localparam int JA_OFF_BIT = 1;
    localparam int TX_PWR_BIT = 0;
    localparam int INVERT_BIT = 4;
    localparam int INT_TERM_BIT = 4;

    // ****************************************
    // Output selector codes
    // ****************************************
    localparam logic [3:0] SEL_STATIC = 4'h0;
    localparam logic [3:0] SEL_RCLK = 4'h1;
    localparam logic [3:0] SEL_SYNC_LOSS = 4'h2;
    localparam logic [3:0] SEL_CARRIER = 4'h3;
    localparam logic [3:0] SEL_REMOTE = 4'h4;
    localparam logic [3:0] SEL_ALL_ONES = 4'h5;
    localparam logic [3:0] SEL_SLIP = 4'h6;
    localparam logic [3:0] SEL_CRC_ERR = 4'h7;
    localparam logic [3:0] SEL_TCLK_LOSS = 4'h8;
    localparam logic [3:0] SEL_FSYNC = 4'h9;
    localparam logic [3:0] SEL_PRBS_ERR = 4'hA;
    localparam logic [3:0] SEL_DATA = 4'hB;
    localparam logic [3:0] SEL_CRC4_MF = 4'hC;
    localparam logic [3:0] SEL_CAS_MF = 4'hD;
    localparam logic [3:0] SEL_CUR_LIM = 4'hE;
    localparam logic [3:0] SEL_RAILS = 4'hF;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 25000000;
    localparam int MCLK_HZ = 2048000;
    localparam int OVERSAMPLE = 16;
    localparam int OS_DIV_RAW = CLK_HZ / (MCLK_HZ * OVERSAMPLE);
    localparam logic [7:0] OS_DIV = (OS_DIV_RAW < 1) ? 8'h01 : 8'(OS_DIV_RAW);
    localparam logic [3:0] PHASE_SAMPLE = 4'h8;
    localparam logic [3:0] HALF_BIT = 4'h8;
    localparam logic [3:0] SHORT_HIGH = 4'h7;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic sync_loss;
        logic carrier_loss;
        logic remote_alarm;
        logic all_ones;
        logic tclk_loss;
        logic slip;
        logic crc_mf_error;
        logic frame_sync;
        logic crc4_mf_sync;
        logic cas_mf_sync;
        logic prbs_error;
        logic tx_nrz_data;
        logic rx_serial_data;
        logic tx_pos_rail;
        logic tx_neg_rail;
    } framer_in_type;

    typedef struct packed {
        logic [2:0] build_out_sel;
        logic eq_gain_limit;
        logic jitter_atten_side;
        logic jitter_buf_depth_sel;
        logic jitter_atten_off;
        logic int_term_select;
    } liu_cfg_type;

endpackage

//--- liu_control_and_output_select.sv
// Line interface control, clock recovery and user output select for one channel.
// Assumes framer inputs are on aclk; line and current-limit pins are asynchronous.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
module liu_control_and_output_select (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Framer side, same clock
    input wire liu_pkg::framer_in_type framer_in,
    // Line side pins
    input wire logic rx_line_p,
    input wire logic rx_line_n,
    input wire logic tx_current_limit,
    output logic tx_line_p_o,
    output logic tx_line_p_oe,
    output logic tx_line_n_o,
    output logic tx_line_n_oe,
    // Recovered receive path
    output logic rx_rec_clk,
    output logic rx_rec_data,
    // Configuration to analog sections
    output liu_pkg::liu_cfg_type liu_cfg,
    // User outputs
    output logic user_out_a,
    output logic user_out_b
);
    import liu_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] lctl;
        logic [7:0] out_a_ctrl;
        logic [7:0] out_b_ctrl;
        logic [7:0] com5;
        logic [2:0] line_p_sync;
        logic [2:0] line_n_sync;
        logic [1:0] cur_sync;
        logic [7:0] os_count;
        logic [3:0] phase;
        logic rclk;
        logic rdata_bit;
        logic [3:0] err_count;
        logic out_a;
        logic out_b;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // ****************************************
    // Helper functions
    // ****************************************

    // Word index from a byte address; misaligned maps to no register
    function automatic logic [7:0] reg_index(input logic [7:0] addr);
        reg_index = (addr[1:0] == 2'b00) ? {2'b00, addr[7:2]} : 8'hFF;
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == COM5_IDX) || (idx == LINE_IDX) || (idx == PINA_IDX)
            || (idx == PINB_IDX) || (idx == STAT_IDX);
    endfunction

    // Raw level for one user output before inversion
    function automatic logic sel_level(
        input logic [3:0] sel,
        input logic is_b,
        input framer_in_type f,
        input logic rclk,
        input logic cur_lim,
        input logic prbs_pulse
    );
        sel_level = 1'b0;
        unique case (sel)
            SEL_STATIC: sel_level = 1'b0;
            SEL_RCLK: sel_level = rclk;
            SEL_SYNC_LOSS: sel_level = f.sync_loss;
            SEL_CARRIER: sel_level = f.carrier_loss;
            SEL_REMOTE: sel_level = f.remote_alarm;
            SEL_ALL_ONES: sel_level = f.all_ones;
            SEL_SLIP: sel_level = f.slip;
            SEL_CRC_ERR: sel_level = f.crc_mf_error & ~f.sync_loss;
            SEL_TCLK_LOSS: sel_level = f.tclk_loss;
            SEL_FSYNC: sel_level = f.frame_sync;
            SEL_PRBS_ERR: sel_level = prbs_pulse;
            SEL_DATA: sel_level = is_b ? f.tx_nrz_data : f.rx_serial_data;
            SEL_CRC4_MF: sel_level = f.crc4_mf_sync;
            SEL_CAS_MF: sel_level = f.cas_mf_sync;
            SEL_CUR_LIM: sel_level = cur_lim;
            SEL_RAILS: sel_level = is_b ? f.tx_pos_rail : f.tx_neg_rail;
        endcase
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************

    logic aw_take;
    logic w_take;
    logic aw_ok;
    logic w_ok;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;
    logic os_tick;
    logic line_mark;
    logic line_edge;
    logic ja_rx_side;
    logic [3:0] high_last;
    logic prbs_pulse;
    logic raw_a;
    logic raw_b;

    // Handshake readies stay combinational off held state
    assign awready = ~state_reg.aw_held & ~state_reg.bvalid;
    assign wready = ~state_reg.w_held & ~state_reg.bvalid;
    assign arready = ~state_reg.rvalid;

    always_comb begin
        state_next = state_reg;
        aw_take = awvalid & awready;
        w_take = wvalid & wready;
        aw_ok = state_reg.aw_held | aw_take;
        w_ok = state_reg.w_held | w_take;
        wr_idx = reg_index(aw_take ? awaddr : state_reg.aw_addr);
        rd_idx = reg_index(araddr);

        // Address and data may come in either order
        if (aw_take) begin
            state_next.aw_addr = awaddr;
        end
        if (w_take) begin
            state_next.w_byte = wdata[7:0];
            state_next.w_lane = wstrb[0];
        end
        state_next.aw_held = aw_ok;
        state_next.w_held = w_ok;

        // Commit once both halves are in; bytes above lane 0 are ignored
        if (aw_ok && w_ok) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = mapped(wr_idx) ? 2'b00 : 2'b10;
            if (w_take ? wstrb[0] : state_reg.w_lane) begin
                unique case (wr_idx)
                    LINE_IDX: state_next.lctl = w_take ? wdata[7:0] : state_reg.w_byte;
                    PINA_IDX: state_next.out_a_ctrl = w_take ? wdata[7:0] : state_reg.w_byte;
                    PINB_IDX: state_next.out_b_ctrl = w_take ? wdata[7:0] : state_reg.w_byte;
                    COM5_IDX: state_next.com5 = w_take ? wdata[7:0] : state_reg.w_byte;
                    default: state_next.bresp = state_next.bresp;
                endcase
            end
        end
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end

        // Read answer registered one cycle after the address
        if (arvalid && arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = mapped(rd_idx) ? 2'b00 : 2'b10;
            unique case (rd_idx)
                LINE_IDX: state_next.rdata = {24'h000000, state_reg.lctl};
                PINA_IDX: state_next.rdata = {24'h000000, state_reg.out_a_ctrl};
                PINB_IDX: state_next.rdata = {24'h000000, state_reg.out_b_ctrl};
                COM5_IDX: state_next.rdata = {24'h000000, state_reg.com5};
                STAT_IDX: state_next.rdata = {24'h000000, state_reg.phase,
                    state_reg.cur_sync[1], framer_in.carrier_loss,
                    state_reg.rdata_bit, state_reg.rclk};
                default: state_next.rdata = 32'h00000000;
            endcase
        end else if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end

        // Pins pass two flops; the third stage keeps the last mark for edges
        state_next.line_p_sync = {state_reg.line_p_sync[1:0], rx_line_p};
        state_next.line_n_sync = {state_reg.line_n_sync[1:0], rx_line_n};
        state_next.cur_sync = {state_reg.cur_sync[0], tx_current_limit};

        // Oversample tick: sixteen ticks per bit period
        os_tick = (state_reg.os_count == OS_DIV - 8'h01);
        state_next.os_count = os_tick ? 8'h00 : state_reg.os_count + 8'h01;
        line_mark = state_reg.line_p_sync[1] | state_reg.line_n_sync[1];
        line_edge = line_mark & ~(state_reg.line_p_sync[2] | state_reg.line_n_sync[2]);

        // Phase realigns on a line mark; free-runs from master clock on loss
        if (os_tick) begin
            if (line_edge && !framer_in.carrier_loss) begin
                state_next.phase = 4'h0;
            end else begin
                state_next.phase = state_reg.phase + 4'h1;
            end
            if (state_reg.phase == PHASE_SAMPLE) begin
                state_next.rdata_bit = line_mark & ~framer_in.carrier_loss;
            end
        end

        // Even duty only with the attenuator enabled on the receive side
        ja_rx_side = ~state_reg.lctl[JA_SIDE_BIT] & ~state_reg.lctl[JA_OFF_BIT];
        high_last = ja_rx_side ? HALF_BIT - 4'h1 : SHORT_HIGH - 4'h1;
        state_next.rclk = (state_next.phase <= high_last);

        // PRBS error held for half a recovered bit period
        if (framer_in.prbs_error) begin
            state_next.err_count = HALF_BIT;
        end else if (os_tick && state_reg.err_count != 4'h0) begin
            state_next.err_count = state_reg.err_count - 4'h1;
        end
        prbs_pulse = (state_reg.err_count != 4'h0);

        // User outputs registered, so a new selector acts on the next clock
        raw_a = sel_level(state_reg.out_a_ctrl[3:0], 1'b0, framer_in, state_reg.rclk,
            state_reg.cur_sync[1], prbs_pulse);
        raw_b = sel_level(state_reg.out_b_ctrl[3:0], 1'b1, framer_in, state_reg.rclk,
            state_reg.cur_sync[1], prbs_pulse);
        state_next.out_a = raw_a ^ state_reg.out_a_ctrl[INVERT_BIT];
        state_next.out_b = raw_b ^ state_reg.out_b_ctrl[INVERT_BIT];
    end

    // ****************************************
    // State register
    // ****************************************

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.lctl <= LINE_RST;
            state_reg.out_a_ctrl <= OUTC_RST;
            state_reg.out_b_ctrl <= OUTC_RST;
            state_reg.com5 <= COM5_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Bus answers
    assign bvalid = state_reg.bvalid;
    assign bresp = state_reg.bresp;
    assign rvalid = state_reg.rvalid;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;

    // Configuration to the analog sections
    assign liu_cfg.build_out_sel = state_reg.lctl[BUILD_OUT_LSB +: 3];
    assign liu_cfg.eq_gain_limit = state_reg.lctl[EQ_GAIN_BIT];
    assign liu_cfg.jitter_atten_side = state_reg.lctl[JA_SIDE_BIT];
    assign liu_cfg.jitter_buf_depth_sel = state_reg.lctl[JA_DEPTH_BIT];
    assign liu_cfg.jitter_atten_off = state_reg.lctl[JA_OFF_BIT];
    assign liu_cfg.int_term_select = state_reg.com5[INT_TERM_BIT];

    // Transmit drivers released while powered down
    assign tx_line_p_o = framer_in.tx_pos_rail & state_reg.lctl[TX_PWR_BIT];
    assign tx_line_n_o = framer_in.tx_neg_rail & state_reg.lctl[TX_PWR_BIT];
    assign tx_line_p_oe = state_reg.lctl[TX_PWR_BIT];
    assign tx_line_n_oe = state_reg.lctl[TX_PWR_BIT];

    // Recovered path and user pins
    assign rx_rec_clk = state_reg.rclk;
    assign rx_rec_data = state_reg.rdata_bit;
    assign user_out_a = state_reg.out_a;
    assign user_out_b = state_reg.out_b;

endmodule

//--- liu_port_checker_assertions.sv
// Port-level checks for the line interface control block.
// Assumes one aclk domain with synchronous active-low aresetn.
module liu_port_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // Line side and recovery
    input wire liu_pkg::framer_in_type framer_in,
    input wire logic tx_line_p_o,
    input wire logic tx_line_p_oe,
    input wire logic tx_line_n_o,
    input wire logic tx_line_n_oe,
    input wire logic rx_rec_clk,
    input wire liu_pkg::liu_cfg_type liu_cfg
);
    import liu_pkg::*;
    // ****************************************
    // Checks
    // ****************************************
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic cl;
    // Carrier loss frees the phase from line edges
    assign cl = framer_in.carrier_loss;
    a_tx_float: assert property (!tx_line_p_oe |-> !tx_line_p_o && !tx_line_n_o && !tx_line_n_oe)
        else $error("transmit driven while powered down");
    a_tx_rails: assert property (tx_line_p_oe |-> tx_line_n_oe && tx_line_p_o == framer_in.tx_pos_rail)
        else $error("transmit rail not following framer");
    a_cfg_write: assert property ($changed(liu_cfg) |-> $rose(bvalid))
        else $error("configuration moved without a write");
    a_oe_write: assert property ($changed(tx_line_p_oe) |-> $rose(bvalid))
        else $error("power state moved without a write");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer dropped early");
    a_read_narrow: assert property (rvalid |-> rdata[31:8] == 24'h000000 && !arready)
        else $error("read upper bits or arready wrong");
    // Free-running recovered clock, duty set by attenuator placement and enable
    a_rclk_even: assert property ($rose(rx_rec_clk) && cl && !liu_cfg.jitter_atten_side &&
        !liu_cfg.jitter_atten_off |-> rx_rec_clk[*8] ##1 !rx_rec_clk)
        else $error("recovered clock not even duty");
    a_rclk_short: assert property ($rose(rx_rec_clk) && cl && (liu_cfg.jitter_atten_side ||
        liu_cfg.jitter_atten_off) |-> rx_rec_clk[*7] ##1 !rx_rec_clk)
        else $error("recovered clock high phase wrong");
    a_rclk_period: assert property ($rose(rx_rec_clk) ##0 cl[*8] ##1 cl[*8] |-> ##1 $rose(rx_rec_clk))
        else $error("fallback clock period not sixteen");
    c_slverr: cover property (bvalid && bresp == 2'h2);
    c_tx_on: cover property ($rose(tx_line_p_oe));
    c_fallback: cover property ($rose(rx_rec_clk) && cl);
endmodule

bind liu_control_and_output_select liu_port_checker u_port_checker (
    .aclk(aclk), .aresetn(aresetn), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .framer_in(framer_in), .tx_line_p_o(tx_line_p_o), .tx_line_p_oe(tx_line_p_oe),
    .tx_line_n_o(tx_line_n_o), .tx_line_n_oe(tx_line_n_oe), .rx_rec_clk(rx_rec_clk), .liu_cfg(liu_cfg)
);

//--- liu_line_model.sv
// Far-side model: framer levels and pulses, receive line marks, current limit.
// Assumes the bench steers it through request ports changed at rising edges.
module liu_line_model (
    // Clock
    input wire logic aclk,
    // Requests from the bench
    input wire liu_pkg::framer_in_type req,
    input wire logic line_on,
    input wire logic cur_req,
    // Towards the block
    output liu_pkg::framer_in_type framer_in,
    output logic rx_line_p,
    output logic rx_line_n,
    output logic tx_current_limit
);
    import liu_pkg::*;
    // Faster than nominal so that lock is visible
    localparam int MARK_GAP = 12;
    int gap_cnt = 0;
    logic pol = 1'b0;
    // Known levels before the first edge
    initial begin
        framer_in = 15'h0000;
        rx_line_p = 1'b0;
        rx_line_n = 1'b0;
        tx_current_limit = 1'b0;
    end
    // Marks alternate polarity, one tick wide, idle line is no mark
    always @(posedge aclk) begin
        framer_in <= req;
        tx_current_limit <= cur_req;
        gap_cnt <= (gap_cnt == MARK_GAP - 1) ? 0 : gap_cnt + 1;
        rx_line_p <= line_on && gap_cnt == 0 && pol;
        rx_line_n <= line_on && gap_cnt == 0 && !pol;
        if (gap_cnt == 0) pol <= !pol;
    end
endmodule

//--- liu_control_and_output_select_tb_top.sv
// Self-checking bench: register access over AXI4-Lite, output selects, recovery.
// Assumes the package, line model and bound checker compile first.
module liu_control_and_output_select_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import liu_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    localparam logic [7:0] A_LINE = {LINE_IDX[5:0], 2'b00};
    localparam logic [7:0] A_PINA = {PINA_IDX[5:0], 2'b00};
    localparam logic [7:0] A_PINB = {PINB_IDX[5:0], 2'b00};
    localparam logic [7:0] A_COM5 = {COM5_IDX[5:0], 2'b00};
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, rx_line_p, rx_line_n, tx_current_limit;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic tx_line_p_o, tx_line_p_oe, tx_line_n_o, tx_line_n_oe, rx_rec_clk, rx_rec_data, user_out_a, user_out_b;
    logic line_on = 1'b0, cur_req = 1'b0;
    framer_in_type req = 15'h0000;
    framer_in_type framer_in;
    liu_cfg_type liu_cfg;
    int error_cnt = 0, n_checks = 0;
    logic [7:0] pat [2] = '{8'hA5, 8'h5A};
    logic [3:0] sel_tab [15] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h9, 4'hB, 4'hB, 4'hC, 4'hD, 4'hF, 4'hF};
    logic [14:0] msk_tab [15] = '{15'h4000, 15'h2000, 15'h1000, 15'h0800, 15'h0200, 15'h0100, 15'h4100,
        15'h0400, 15'h0080, 15'h0004, 15'h0008, 15'h0040, 15'h0020, 15'h0001, 15'h0002};
    logic [1:0] exp_tab [15] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h3, 2'h2, 2'h1, 2'h3, 2'h3, 2'h2, 2'h1};
    // 25 MHz clock
    always #20 aclk = ~aclk;
    liu_control_and_output_select dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .framer_in(framer_in),
        .rx_line_p(rx_line_p), .rx_line_n(rx_line_n), .tx_current_limit(tx_current_limit),
        .tx_line_p_o(tx_line_p_o), .tx_line_p_oe(tx_line_p_oe), .tx_line_n_o(tx_line_n_o),
        .tx_line_n_oe(tx_line_n_oe), .rx_rec_clk(rx_rec_clk), .rx_rec_data(rx_rec_data), .liu_cfg(liu_cfg),
        .user_out_a(user_out_a), .user_out_b(user_out_b));
    liu_line_model line_side (.aclk(aclk), .req(req), .line_on(line_on), .cur_req(cur_req),
        .framer_in(framer_in), .rx_line_p(rx_line_p), .rx_line_n(rx_line_n), .tx_current_limit(tx_current_limit));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic fin(input string name);
        $display("test %s finished, %0d mismatches so far", name, error_cnt);
    endtask
    // Address and data offered together, each freed when taken
    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_done = 1'b0, w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw_done) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_word("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk_word("rdata", ed, rdata);
        chk_word("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask
    // High samples and rises of out_a or recovered clock
    task automatic count(input int n, input logic pick, output int hi, output int rs);
        logic prev, cur;
        hi = 0;
        rs = 0;
        prev = pick ? user_out_a : rx_rec_clk;
        repeat (n) begin
            @(negedge aclk);
            cur = pick ? user_out_a : rx_rec_clk;
            hi += int'(cur === 1'b1);
            rs += int'(cur === 1'b1 && prev === 1'b0);
            prev = cur;
        end
    endtask
    // One framer pulse; A plain, B inverted; exact two-edge latency
    task automatic pulse(input int i);
        wr_chk(A_PINA, {4'h0, sel_tab[i]}, 2'h0);
        wr_chk(A_PINB, {4'h1, sel_tab[i]}, 2'h0);
        @(posedge aclk);
        req <= msk_tab[i];
        @(posedge aclk);
        req <= 15'h0000;
        @(negedge aclk);
        chk_bit("a early", 1'b0, user_out_a);
        @(negedge aclk);
        chk_bit("a pulse", exp_tab[i][1], user_out_a);
        chk_bit("b pulse", !exp_tab[i][0], user_out_b);
        @(negedge aclk);
        chk_bit("a end", 1'b0, user_out_a);
        chk_bit("b end", 1'b1, user_out_b);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        int hi, rs;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(A_LINE, 32'h0, 2'h0);
        rd_chk(A_PINA, 32'h0, 2'h0);
        rd_chk(A_PINB, 32'h0, 2'h0);
        rd_chk(A_COM5, 32'h0, 2'h0);
        chk_bit("tx oe", 1'b0, tx_line_p_oe);
        fin("reset values");
        req <= 15'h0003;
        for (int i = 0; i < 2; i++) begin
            wr_chk(A_LINE, pat[i], 2'h0);
            rd_chk(A_LINE, {24'h0, pat[i]}, 2'h0);
            tick(1);
            chk_word("liu_cfg", {24'h0, pat[i][7:1], 1'b0}, {24'h0, liu_cfg});
            chk_bit("tx oe", pat[i][0], tx_line_p_oe);
            chk_bit("tx pos", pat[i][0], tx_line_p_o);
            chk_bit("tx neg", pat[i][0], tx_line_n_o);
        end
        wr_chk(A_COM5, 8'h10, 2'h0);
        tick(1);
        chk_bit("int term", 1'b1, liu_cfg.int_term_select);
        fin("line control");
        wr_chk(8'h70, 8'hFF, 2'h2);
        wr_chk(A_LINE + 8'h01, 8'hFF, 2'h2);
        rd_chk(8'h70, 32'h0, 2'h2);
        rd_chk(A_LINE, 32'h0000005A, 2'h0);
        fin("bus errors");
        req <= 15'h0000;
        wr_chk(A_PINA, 8'h10, 2'h0);
        @(negedge aclk);
        chk_bit("static a", 1'b1, user_out_a);
        wr_chk(A_PINA, 8'h00, 2'h0);
        @(negedge aclk);
        chk_bit("static a", 1'b0, user_out_a);
        for (int i = 0; i < 15; i++) pulse(i);
        fin("output selects");
        wr_chk(A_PINA, {4'h0, SEL_PRBS_ERR}, 2'h0);
        @(posedge aclk);
        req <= 15'h0010;
        @(posedge aclk);
        req <= 15'h0000;
        count(20, 1'b1, hi, rs);
        chk_word("prbs width", 32'h8, hi);
        wr_chk(A_PINA, {4'h0, SEL_CUR_LIM}, 2'h0);
        cur_req <= 1'b1;
        tick(6);
        chk_bit("cur lim on", 1'b1, user_out_a);
        @(posedge aclk);
        cur_req <= 1'b0;
        tick(6);
        chk_bit("cur lim off", 1'b0, user_out_a);
        fin("error and limit outputs");
        wr_chk(A_LINE, 8'h01, 2'h0);
        wr_chk(A_PINA, {4'h0, SEL_RCLK}, 2'h0);
        count(32, 1'b1, hi, rs);
        chk_word("rclk on out_a", 32'h10, hi);
        @(posedge aclk);
        line_on <= 1'b1;
        tick(30);
        count(48, 1'b0, hi, rs);
        chk_word("locked rises", 32'h4, rs);
        chk_bit("rec data", 1'b0, rx_rec_data);
        @(posedge aclk);
        req <= 15'h2000;
        tick(4);
        count(48, 1'b0, hi, rs);
        chk_word("fallback rises", 32'h3, rs);
        @(posedge aclk);
        line_on <= 1'b0;
        tick(4);
        @(posedge aclk);
        req <= 15'h0000;
        tick(20);
        wr_chk(A_LINE, 8'h03, 2'h0);
        req <= 15'h2000;
        tick(2);
        count(48, 1'b0, hi, rs);
        chk_word("short duty", 32'h15, hi);
        fin("clock recovery");
        conclude();
    end
    // Tests take under 3000 cycles
    initial begin
        #400000;
        error_cnt++;
        $display("[FAIL] watchdog expected finish seen timeout");
        conclude();
    end
endmodule
